/* bench/oversampling_average_filter_tb.sv */
// Self-checking bench for the oversampling average filter
`timescale 1ns/1ps
module oversampling_average_filter_tb;
   localparam int CH = average_filter_pkg::CHANNELS;
   localparam int W  = CH * 16;
   // Clock, reset and pins
   logic          clk_sys = 1'b0;
   logic          reset_n = 1'b0;
   logic [2:0]    ratio_sel = 3'h0;
   logic          ref_sel = 1'b0, range_sel = 1'b0;
   logic          go = 1'b0, start_a, start_b;
   logic [3:0]    high_cycles = 4'h3;
   // Core side and outputs
   logic          req, done = 1'b0, res_valid, ref_en, ref_oe, amp_en;
   logic          busy, invalid;
   logic [W-1:0]  sdata = '0, res_data;
   logic [CH-1:0] gain_wide;
   logic [2:0]    dly = 3'h0;   // Core conversion latency pipe
   int            dcount = 0, req_cnt = 0;
   // Register port
   logic [3:0]    addr = 4'h0;
   logic [31:0]   wdata = 32'h0000_0000, rdata;
   logic          wr = 1'b0, rd = 1'b0;
   int            miscompares = 0, num_checks = 0;

   always #5 clk_sys = ~clk_sys;

   oversampling_average_filter oversampling_average_filter_i (
      .i_clk_sys(clk_sys), .i_reset_n(reset_n),
      .i_oversample_ratio_select(ratio_sel),
      .i_convert_start_group_a(start_a), .i_convert_start_group_b(start_b),
      .i_reference_source_select(ref_sel), .i_range_select(range_sel),
      .o_sample_request(req), .i_sample_done(done), .i_sample_data(sdata),
      .o_result_valid(res_valid), .o_result_data(res_data),
      .o_internal_ref_enable(ref_en), .o_ref_pin_oe(ref_oe),
      .o_ref_amp_enable(amp_en), .o_input_gain_amplifier_wide(gain_wide),
      .o_busy(busy), .o_ratio_invalid(invalid),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr),
      .i_reg_read(rd), .o_reg_rdata(rdata));

   start_host_model start_host_model_i (
      .i_clk_sys(clk_sys), .i_go(go), .i_high_cycles(high_cycles),
      .o_start_a(start_a), .o_start_b(start_b));

   ////////////////////////////////////////////////////////////////////////////
   // Signed test sample of channel c for the j-th conversion overall
   function automatic int sval(int c, int j);
      return c * 1500 - 4000 + j * 37;
   endfunction : sval

   // Core stand-in: answers each request three cycles later; data lines
   // toggle outside the done cycle so stale values never look valid
   always @(posedge clk_sys) begin
      dly  <= {dly[1:0], req};
      done <= dly[1];
      if (dly[1]) begin
         for (int c = 0; c < CH; c++) sdata[c*16 +: 16] <= 16'(sval(c, dcount));
         dcount <= dcount + 1;
      end else begin
         sdata <= ~sdata;
      end
      if (req) req_cnt <= req_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(logic [W-1:0] got, logic [W-1:0] exp, string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic reg_write(logic [3:0] a, logic [31:0] d);
      @(posedge clk_sys);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a; rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_read

   task automatic wait_cycles(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cycles

   ////////////////////////////////////////////////////////////////////////////
   // One averaging run at a given ratio code, result checked per channel
   task automatic run_ratio(logic [2:0] code);
      int d0, r0, sum, n;
      logic [W-1:0] exp;
      logic [31:0] d;
      @(posedge clk_sys);
      ratio_sel <= code;
      wait_cycles(5);
      d0 = dcount; r0 = req_cnt; n = 1 << code;
      @(posedge clk_sys) go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      // Start edge passes the synchroniser, then the run is under way
      wait_cycles(4);
      check(W'(busy), W'(1), "busy during run");
      for (int t = 0; t < 3000 && !res_valid; t++) @(posedge clk_sys) #1;
      if (!res_valid) begin
         miscompares++;
         $display("ERROR at %0t: no result within limit", $time);
         tally_and_finish();
      end
      for (int c = 0; c < CH; c++) begin
         sum = 0;
         for (int k = 0; k < n; k++) sum += sval(c, d0 + k);
         exp[c*16 +: 16] = 16'(sum >>> code);
      end
      check(res_data, exp, "averaged words");
      check(W'(req_cnt - r0), W'(n), "sample count");
      check(W'(invalid), W'(0), "invalid flag cleared");
      check(W'(busy), W'(0), "idle after result");
      reg_read(average_filter_pkg::ADDR_STATUS, d);
      check(W'({d[6:4], d[0]}), W'({code, 1'b0}), "status ratio");
      $display("Test run ratio code %0d done", code);
   endtask : run_ratio

   task automatic test_invalid_code();
      logic [31:0] d;
      int r0;
      @(posedge clk_sys);
      ratio_sel <= 3'h7;
      wait_cycles(5);
      r0 = req_cnt;
      @(posedge clk_sys) go <= 1'b1;
      @(posedge clk_sys) go <= 1'b0;
      wait_cycles(20);
      check(W'(invalid), W'(1), "invalid flag");
      check(W'(req_cnt - r0), W'(0), "no samples");
      reg_read(average_filter_pkg::ADDR_STATUS, d);
      check(W'(d[1]), W'(1), "status invalid bit");
      $display("Test invalid ratio code done");
   endtask : test_invalid_code

   task automatic test_pins(logic r, logic g);
      logic [31:0] d;
      @(posedge clk_sys);
      ref_sel <= r; range_sel <= g;
      wait_cycles(5);
      check(W'({ref_en, ref_oe, amp_en}), W'({r, r, 1'b1}), "reference");
      check(W'(gain_wide), W'({CH{g}}), "gain select");
      reg_read(average_filter_pkg::ADDR_STATUS, d);
      check(W'(d[3:2]), W'({g, r}), "status pins");
      $display("Test pins ref %0b range %0b done", r, g);
   endtask : test_pins

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1;
      // amplifier on straight out of reset
      check(W'({amp_en, busy}), W'(2'b10), "reset outputs");
      reg_read(average_filter_pkg::ADDR_SPACING, d);
      check(W'(d), W'(average_filter_pkg::SPACING_RESET), "spacing reset");
      reg_read(4'hC, d);
      check(W'(d), W'(0), "unmapped read");
      reg_write(4'hC, 32'h0000_0055);
      reg_write(average_filter_pkg::ADDR_SPACING, 32'h0000_0002);
      reg_read(average_filter_pkg::ADDR_SPACING, d);
      check(W'(d), W'(32'h0000_0002), "spacing write");
      test_pins(1'b1, 1'b1);
      test_pins(1'b0, 1'b0);
      test_pins(1'b1, 1'b0);
      for (int i = 0; i < 7; i++) run_ratio(3'(i));
      test_invalid_code();
      high_cycles <= 4'hC;
      run_ratio(3'h2);
      reg_read(average_filter_pkg::ADDR_RUNS, d);
      check(W'(d), W'(8), "run count");
      tally_and_finish();
   end
endmodule : oversampling_average_filter_tb

/* bench/start_host_model.sv */
// Host side model: drives both conversion start pins on command
`timescale 1ns/1ps
module start_host_model (
   // Clock
   input  wire logic       i_clk_sys,
   // Command from the bench
   input  wire logic       i_go,
   input  wire logic [3:0] i_high_cycles,
   // Start pins toward the device
   output logic            o_start_a,
   output logic            o_start_b
);
   logic [3:0] left_reg;   // Cycles the pins still stay high
   initial begin
      o_start_a = 1'b0;
      o_start_b = 1'b0;
      left_reg  = 4'h0;
   end
   ///////////////////////////////////////////////////////////////////////////
   // Pulse both groups together; the bench only commands a new run after
   // the previous result, so the rate limit is never exceeded
   // host paced start rising edge
   always @(posedge i_clk_sys) begin
      if (i_go) begin
         o_start_a <= 1'b1;
         o_start_b <= 1'b1;
         left_reg  <= i_high_cycles;
      end else if (left_reg != 4'h0) begin
         left_reg <= left_reg - 4'h1;
         // Pins fall together so no second edge is seen
         if (left_reg == 4'h1) begin
            o_start_a <= 1'b0;
            o_start_b <= 1'b0;
         end
      end
   end
endmodule : start_host_model

/* design/average_filter_pkg.sv */
// Constants and types shared by the oversampling average filter
package average_filter_pkg;
   // Data path sizes
   localparam int SAMPLE_WIDTH    = 16;
   localparam int CHANNELS        = 6;
   localparam int RATIO_SEL_WIDTH = 3;
   localparam int MAX_RATIO_LOG2  = 6;
   localparam int COUNT_WIDTH     = MAX_RATIO_LOG2 + 1;
   // Ratio select code that names no ratio
   localparam logic [2:0] RATIO_SEL_INVALID = 3'h7;
   // Internal pacing between samples of a run, one conversion slot
   localparam int CLK_PERIOD_NS        = 10;
   localparam int SAMPLE_PERIOD_NS     = 4000;
   localparam int SAMPLE_PERIOD_CYCLES =
      (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] SPACING_RESET = 16'(SAMPLE_PERIOD_CYCLES);
   // Register port
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 32;
   localparam logic [3:0] ADDR_STATUS  = 4'h0;
   localparam logic [3:0] ADDR_SPACING = 4'h4;
   localparam logic [3:0] ADDR_RUNS    = 4'h8;
   // Status register fields
   localparam int STATUS_BUSY_BIT    = 0;
   localparam int STATUS_INVALID_BIT = 1;
   localparam int STATUS_INTREF_BIT  = 2;
   localparam int STATUS_RANGE_BIT   = 3;
   localparam int STATUS_RATIO_LSB   = 4;
   // Run sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_GAP} run_state_t;
endpackage : average_filter_pkg

/* design/oversampling_average_filter.sv */
// Oversampling average and decimation filter with pin configuration
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Ratio pins pick 1..64; code 111 invalid
// R2: Host keeps rate within ratio maximum
// R3: First sample taken on start rising edge
// R4: Later samples paced by internal control
// R5: Average run, one 16-bit word per channel
// R6: Reference amplifier always enabled
// R7: Range pin sets all channel gains alike
// R8: Reference pin high: internal, low: external
// R9: Range pin picks 10 V or 5 V
// R10: Results are two's complement 16-bit
// R11: Wide accumulator then shift by log2
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module oversampling_average_filter #(
   parameter int CHANNELS = average_filter_pkg::CHANNELS
) (
   // Clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_reset_n,
   // Configuration and start pins from the host
   input  wire logic [2:0]                 i_oversample_ratio_select,
   input  wire logic                       i_convert_start_group_a,
   input  wire logic                       i_convert_start_group_b,
   input  wire logic                       i_reference_source_select,
   input  wire logic                       i_range_select,
   // Converter core
   output logic                            o_sample_request,
   input  wire logic                       i_sample_done,
   input  wire logic [CHANNELS*16-1:0]     i_sample_data,
   // Averaged results
   output logic                            o_result_valid,
   output logic [CHANNELS*16-1:0]          o_result_data,
   // Analog controls
   output logic                            o_internal_ref_enable,
   output logic                            o_ref_pin_oe,
   output logic                            o_ref_amp_enable,
   output logic [CHANNELS-1:0]             o_input_gain_amplifier_wide,
   // Status
   output logic                            o_busy,
   output logic                            o_ratio_invalid,
   // Register port
   input  wire logic [3:0]                 i_reg_addr,
   input  wire logic [31:0]                i_reg_wdata,
   input  wire logic                       i_reg_write,
   input  wire logic                       i_reg_read,
   output logic [31:0]                     o_reg_rdata
);
   localparam int SW    = average_filter_pkg::SAMPLE_WIDTH;
   localparam int CW    = average_filter_pkg::COUNT_WIDTH;
   localparam int ACC_W = SW + average_filter_pkg::MAX_RATIO_LOG2;

   // Refuse a channel count the flat buses cannot carry; checked while
   // the design is built, so a bad build stops before any clock runs
   if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
      $error("CHANNELS must lie between 1 and 8");
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: two flops, stage one read only by stage two
   logic [6:0] pin_meta_reg;    // First stage
   logic [6:0] pin_sync_reg;    // Second stage, safe to use
   logic [6:0] pin_meta_next;
   logic [6:0] pin_sync_next;
   logic [2:0] ratio_sel;       // Synchronised ratio code
   logic       start_level;     // Both start groups high
   logic       ref_internal;    // Reference select level
   logic       range_wide;      // Range select level

   always_comb begin
      pin_meta_next = {i_range_select, i_reference_source_select,
                       i_convert_start_group_b, i_convert_start_group_a,
                       i_oversample_ratio_select};
      pin_sync_next = pin_meta_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         pin_meta_reg <= 7'h00;
         pin_sync_reg <= 7'h00;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
      end
   end

   assign ratio_sel    = pin_sync_reg[2:0];
   assign start_level  = pin_sync_reg[3] & pin_sync_reg[4];
   assign ref_internal = pin_sync_reg[5];
   assign range_wide   = pin_sync_reg[6];

   //////////////////////////////////////////////////////////////////////////
   // Analog control outputs, registered except the constant amplifier enable
   logic                ref_int_reg;
   logic [CHANNELS-1:0] gain_reg;
   logic                ref_int_next;
   logic [CHANNELS-1:0] gain_next;

   always_comb begin
      // R8: reference select choice
      ref_int_next = ref_internal;
      // R7: one gain setting for all
      gain_next    = {CHANNELS{range_wide}};
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ref_int_reg <= 1'b0;
         gain_reg    <= '0;
      end else begin
         ref_int_reg <= ref_int_next;
         gain_reg    <= gain_next;
      end
   end

   // Pin is driven only when the internal reference feeds it
   assign o_internal_ref_enable = ref_int_reg;
   assign o_ref_pin_oe          = ref_int_reg;
   // R6: amplifier never powered down
   assign o_ref_amp_enable      = 1'b1;
   // R9: high selects the 10 V span
   assign o_input_gain_amplifier_wide = gain_reg;

   //////////////////////////////////////////////////////////////////////////
   // Run sequencer and accumulators
   average_filter_pkg::run_state_t state_reg, state_next;
   logic               start_prev_reg, start_prev_next;
   logic               start_edge;      // Rising edge of start level
   logic [2:0]         log_reg, log_next;
   logic [CW-1:0]      count_reg, count_next;
   logic [15:0]        gap_reg, gap_next;
   logic               req_reg, req_next;
   logic               valid_reg, valid_next;
   logic               invalid_reg, invalid_next;
   logic [31:0]        runs_reg, runs_next;
   logic [15:0]        spacing_reg;
   logic [CW-1:0]      target;          // Samples in the current run
   logic signed [ACC_W-1:0] acc_reg [CHANNELS];
   logic signed [ACC_W-1:0] acc_next [CHANNELS];
   logic signed [ACC_W-1:0] acc_sum [CHANNELS];
   logic signed [ACC_W-1:0] acc_shift [CHANNELS];
   logic [SW-1:0]      res_reg [CHANNELS];
   logic [SW-1:0]      res_next [CHANNELS];

   assign start_edge = start_level & ~start_prev_reg;
   assign target     = CW'(1) << log_reg;

   // Next-state logic: one pass covers every channel
   always_comb begin
      state_next      = state_reg;
      start_prev_next = start_level;
      log_next        = log_reg;
      count_next      = count_reg;
      gap_next        = gap_reg;
      req_next        = 1'b0;
      valid_next      = 1'b0;
      invalid_next    = invalid_reg;
      runs_next       = runs_reg;
      for (int c = 0; c < CHANNELS; c++) begin
         // R11: sign-extended sum, no overflow at ratio 64
         acc_sum[c]   = acc_reg[c] +
                        ACC_W'($signed(i_sample_data[c*SW +: SW]));
         acc_shift[c] = acc_sum[c] >>> log_reg;
         acc_next[c]  = acc_reg[c];
         res_next[c]  = res_reg[c];
      end
      case (state_reg)
         // Wait for the host's start edge
         average_filter_pkg::ST_IDLE: begin
            if (start_edge) begin
               // R1: invalid code blocks the run
               if (ratio_sel == average_filter_pkg::RATIO_SEL_INVALID) begin
                  invalid_next = 1'b1;
               end else begin
                  // R3: first sample on the edge
                  invalid_next = 1'b0;
                  log_next     = ratio_sel;
                  count_next   = '0;
                  req_next     = 1'b1;
                  state_next   = average_filter_pkg::ST_CONVERT;
                  for (int c = 0; c < CHANNELS; c++) begin
                     acc_next[c] = '0;
                  end
               end
            end
         end
         // Collect one conversion from the core
         average_filter_pkg::ST_CONVERT: begin
            if (i_sample_done) begin
               count_next = count_reg + CW'(1);
               for (int c = 0; c < CHANNELS; c++) begin
                  acc_next[c] = acc_sum[c];
               end
               if (count_next == target) begin
                  // R5: decimate to one word
                  valid_next = 1'b1;
                  runs_next  = runs_reg + 32'h0000_0001;
                  state_next = average_filter_pkg::ST_IDLE;
                  for (int c = 0; c < CHANNELS; c++) begin
                     // R10: low bits keep two's complement
                     res_next[c] = acc_shift[c][SW-1:0];
                  end
               end else begin
                  // A zero spacing would wrap to a 65536-cycle gap, so floor it at one
                  gap_next   = (spacing_reg == 16'h0000) ? 16'h0001
                                                         : spacing_reg;
                  state_next = average_filter_pkg::ST_GAP;
               end
            end
         end
         // R4: internal pacing of later samples
         average_filter_pkg::ST_GAP: begin
            gap_next = gap_reg - 16'h0001;
            if (gap_reg == 16'h0001) begin
               req_next   = 1'b1;
               state_next = average_filter_pkg::ST_CONVERT;
            end
         end
         default: begin
            state_next = average_filter_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state_reg      <= average_filter_pkg::ST_IDLE;
         start_prev_reg <= 1'b0;
         log_reg        <= 3'h0;
         count_reg      <= '0;
         gap_reg        <= 16'h0000;
         req_reg        <= 1'b0;
         valid_reg      <= 1'b0;
         invalid_reg    <= 1'b0;
         runs_reg       <= 32'h0000_0000;
         for (int c = 0; c < CHANNELS; c++) begin
            acc_reg[c] <= '0;
            res_reg[c] <= '0;
         end
      end else begin
         state_reg      <= state_next;
         start_prev_reg <= start_prev_next;
         log_reg        <= log_next;
         count_reg      <= count_next;
         gap_reg        <= gap_next;
         req_reg        <= req_next;
         valid_reg      <= valid_next;
         invalid_reg    <= invalid_next;
         runs_reg       <= runs_next;
         for (int c = 0; c < CHANNELS; c++) begin
            acc_reg[c] <= acc_next[c];
            res_reg[c] <= res_next[c];
         end
      end
   end

   assign o_sample_request = req_reg;
   assign o_result_valid   = valid_reg;
   assign o_busy           = (state_reg != average_filter_pkg::ST_IDLE);
   assign o_ratio_invalid  = invalid_reg;
   for (genvar g = 0; g < CHANNELS; g++) begin : g_res
      assign o_result_data[g*SW +: SW] = res_reg[g];
   end

   //////////////////////////////////////////////////////////////////////////
   // Register port: spacing is writable, status and run count read back
   logic [15:0] spacing_next;
   logic [31:0] rdata_reg, rdata_next;

   always_comb begin
      spacing_next = spacing_reg;
      rdata_next   = 32'h0000_0000;
      if (i_reg_write && i_reg_addr == average_filter_pkg::ADDR_SPACING) begin
         spacing_next = i_reg_wdata[15:0];
      end
      if (i_reg_read) begin
         if (i_reg_addr == average_filter_pkg::ADDR_STATUS) begin
            rdata_next[average_filter_pkg::STATUS_BUSY_BIT]    = o_busy;
            rdata_next[average_filter_pkg::STATUS_INVALID_BIT] = invalid_reg;
            rdata_next[average_filter_pkg::STATUS_INTREF_BIT]  = ref_int_reg;
            rdata_next[average_filter_pkg::STATUS_RANGE_BIT]   = gain_reg[0];
            rdata_next[average_filter_pkg::STATUS_RATIO_LSB +: 3] = log_reg;
         end else if (i_reg_addr == average_filter_pkg::ADDR_SPACING) begin
            rdata_next[15:0] = spacing_reg;
         end else if (i_reg_addr == average_filter_pkg::ADDR_RUNS) begin
            rdata_next = runs_reg;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         spacing_reg <= average_filter_pkg::SPACING_RESET;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         spacing_reg <= spacing_next;
         rdata_reg   <= rdata_next;
      end
   end

   assign o_reg_rdata = rdata_reg;

   //////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and outputs
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   logic idle_go;   // Valid start taken this cycle
   assign idle_go = (state_reg == average_filter_pkg::ST_IDLE) && start_edge
                    && (ratio_sel != average_filter_pkg::RATIO_SEL_INVALID);

   ratio_latch_a: assert property (idle_go |=> log_reg == $past(ratio_sel)) // R1
      else $error("ratio not latched from select pins");
   invalid_hold_a: assert property ( // R1
      (state_reg == average_filter_pkg::ST_IDLE) && start_edge && !idle_go
      |=> !o_sample_request && !o_busy && o_ratio_invalid)
      else $error("invalid ratio code started a run");
   first_sample_a: assert property (idle_go |=> o_sample_request && o_busy) // R3
      else $error("first sample missing after start edge");
   internal_pace_a: assert property ( // R4
      (state_reg == average_filter_pkg::ST_GAP) && gap_reg == 16'h0001
      |=> o_sample_request ##1 !o_sample_request)
      else $error("internal pacing did not request a sample");
   run_end_a: assert property ( // R5
      o_result_valid |-> $past(i_sample_done) && !o_busy
      && $past(count_reg) + CW'(1) == $past(target))
      else $error("result word without a full run");
   amp_enabled_a: assert property (o_ref_amp_enable) // R6
      else $error("reference amplifier disabled");
   gain_common_a: assert property ( // R7
      o_input_gain_amplifier_wide == {CHANNELS{$past(range_wide)}})
      else $error("channel gains differ from range pin");
   ref_select_a: assert property ( // R8
      o_internal_ref_enable == $past(ref_internal)
      && o_ref_pin_oe == o_internal_ref_enable)
      else $error("reference source does not follow pin");
   range_span_a: assert property ( // R9
      $changed(range_wide) |=> o_input_gain_amplifier_wide[0]
      == $past(range_wide))
      else $error("range change not applied");
   sign_keep_a: assert property ( // R10
      o_result_valid |-> o_result_data[SW-1] == $past(acc_sum[0][ACC_W-1]))
      else $error("result sign lost");
   shift_scale_a: assert property ( // R11
      o_result_valid |-> res_reg[0] == $past(acc_shift[0][SW-1:0]))
      else $error("result is not the shifted accumulator");

   run64_c:   cover property (o_result_valid && log_reg == 3'h6);
   single_c:  cover property (o_result_valid && log_reg == 3'h0);
   invalid_c: cover property ($rose(o_ratio_invalid));
   pace_c:    cover property (state_reg == average_filter_pkg::ST_GAP
                              ##1 o_sample_request);
endmodule : oversampling_average_filter
